/* hdl/dmc_ctrl.sv */
// Notes on behaviour
// - Reset clears every channel control register to all zeros.
// - Control contents hold while in standby or module standby.
// - Bits 31:24 and 21:18 read zero; software writes zero.
// - Bit 23 selects overrun-0 or overrun-1 request detection.
// - Bit 22 sets transfer-end output polarity: zero low, one high.
// - Dual address: bit 17 zero acks in read, one in write cycle.
// - Single address: ack asserted every transfer regardless of bit 17.
// - Bit 16 sets ack output polarity: zero low, one high.
// - Bits 23, 22, 17, 16 exist only on channels 0 and 1.
// - Destination mode bits 15:14: fixed, increment, decrement; 11 forbidden.
// - Destination increment adds 1, 2, 4 or 16 per unit.
// - Destination decrement subtracts 1, 2 or 4 per unit.
// - Single address to external device ignores destination mode bits.
// - Source mode bits 13:12: fixed, increment, decrement; 11 forbidden.
// - Single address from external device ignores source mode bits.
// - Size field encodes byte as 00 and word as 01.
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module dmc_ctrl (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [dmc_pkg::AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic standby_i,
  input wire logic module_stop_i,
  input wire logic [dmc_pkg::NCH-1:0] unit_done_i,
  input wire logic [dmc_pkg::NEXT-1:0] rd_cycle_i,
  input wire logic [dmc_pkg::NEXT-1:0] wr_cycle_i,
  input wire logic [dmc_pkg::NEXT-1:0] end_cycle_i,
  output logic [dmc_pkg::NEXT-1:0] xfer_ack_out_o,
  output logic [dmc_pkg::NEXT-1:0] xfer_end_out_o,
  output logic [dmc_pkg::NEXT-1:0] overrun_sel_o,
  output logic [dmc_pkg::NCH*32-1:0] src_addr_o,
  output logic [dmc_pkg::NCH*32-1:0] dst_addr_o
);
  import dmc_pkg::*;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic hold_w;
  logic [2:0] ch_w;
  logic [1:0] sel_w;
  logic hit_w;
  logic done_w;
  logic wr_go_w;
  logic [31:0] rd_word_w;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] ctrl_w [NCH];
  logic [31:0] src_w [NCH];
  logic [31:0] dst_w [NCH];
  logic [NCH-1:0] single_w;
  logic [NCH-1:0] to_dev_w;
  logic [NCH-1:0] from_dev_w;
  logic [NEXT-1:0] ovr_q;

  assign hold_w = standby_i | module_stop_i;
  assign ch_w = paddr_i[6:4];
  assign sel_w = paddr_i[3:2];
  assign hit_w = !paddr_i[7] && (ch_w < 3'(NCH)) && (sel_w != 2'h3) &&
                 (paddr_i[1:0] == 2'h0);
  assign done_w = psel_i & penable_i & pready_q;
  assign wr_go_w = done_w & pwrite_i & hit_w & ~hold_w;
  assign rd_word_w = !hit_w ? 32'h0000_0000 :
                     (sel_w == SEL_SRC) ? src_w[ch_w] :
                     (sel_w == SEL_DST) ? dst_w[ch_w] : ctrl_w[ch_w];

  // ----------------------------------------
  // apb answer, one wait state
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel_i & penable_i & ~pready_q;
      pslverr_q <= psel_i & penable_i & ~pready_q & ~hit_w;
      if (psel_i & penable_i & ~pready_q)
        prdata_q <= pwrite_i ? 32'h0000_0000 : rd_word_w;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;

  // ----------------------------------------
  // per-channel registers
  // ----------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    localparam logic [31:0] MASK = (c < NEXT) ? CTRL_MASK_EXT : CTRL_MASK_INT;
    logic [31:0] ctrl_q;
    logic [31:0] src_q;
    logic [31:0] dst_q;
    logic [31:0] src_nx_w;
    logic [31:0] dst_nx_w;
    logic sel_me_w;
    logic [3:0] rs_w;

    assign sel_me_w = wr_go_w && (ch_w == 3'(c));
    assign rs_w = ctrl_q[RS_LO+:4];
    assign to_dev_w[c] = (c < NEXT) && (rs_w == RS_SGL_TO_DEV);
    assign from_dev_w[c] = (c < NEXT) && (rs_w == RS_SGL_FROM_DEV);
    assign single_w[c] = to_dev_w[c] | from_dev_w[c];

    dmc_addr_step u_src (
      .addr_i (src_q),
      .mode_i (ctrl_q[SRC_LO+:2]),
      .size_i (ctrl_q[SZ_LO+:2]),
      .ignore_i (from_dev_w[c]),
      .next_o (src_nx_w)
    );

    dmc_addr_step u_dst (
      .addr_i (dst_q),
      .mode_i (ctrl_q[DST_LO+:2]),
      .size_i (ctrl_q[SZ_LO+:2]),
      .ignore_i (to_dev_w[c]),
      .next_o (dst_nx_w)
    );

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        ctrl_q <= CTRL_RST;
      end else if (sel_me_w && sel_w == SEL_CTL) begin
        ctrl_q <= pwdata_i & MASK;
      end
    end

    // a bus write wins over a step in the same cycle
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        src_q <= ADDR_RST;
        dst_q <= ADDR_RST;
      end else begin
        if (sel_me_w && sel_w == SEL_SRC)
          src_q <= pwdata_i;
        else if (unit_done_i[c] && !hold_w)
          src_q <= src_nx_w;
        if (sel_me_w && sel_w == SEL_DST)
          dst_q <= pwdata_i;
        else if (unit_done_i[c] && !hold_w)
          dst_q <= dst_nx_w;
      end
    end

    assign ctrl_w[c] = ctrl_q;
    assign src_w[c] = src_q;
    assign dst_w[c] = dst_q;
    assign src_addr_o[c*32+:32] = src_q;
    assign dst_addr_o[c*32+:32] = dst_q;
  end

  // ----------------------------------------
  // external handshake outputs
  // ----------------------------------------
  for (genvar e = 0; e < NEXT; e++) begin : g_ext
    dmc_hs_out u_hs (
      .mclk_i (mclk_i),
      .rst_n_i (rst_n_i),
      .hold_i (hold_w),
      .single_i (single_w[e]),
      .ack_on_write_i (ctrl_w[e][ACS_BIT]),
      .ack_high_i (ctrl_w[e][ACP_BIT]),
      .end_high_i (ctrl_w[e][TEP_BIT]),
      .rd_cycle_i (rd_cycle_i[e]),
      .wr_cycle_i (wr_cycle_i[e]),
      .end_cycle_i (end_cycle_i[e]),
      .ack_o (xfer_ack_out_o[e]),
      .end_o (xfer_end_out_o[e])
    );

    // detection mode handed to the request sampler
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i)
        ovr_q[e] <= 1'b0;
      else
        ovr_q[e] <= ctrl_w[e][OVR_BIT];
    end
  end

  assign overrun_sel_o = ovr_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  logic [31:0] ctl0_w;
  logic [31:0] ctl2_w;
  logic [1:0] sz0_w;
  logic [1:0] dm0_w;
  logic [1:0] sm0_w;

  assign ctl0_w = ctrl_w[0];
  assign ctl2_w = ctrl_w[2];
  assign sz0_w = ctl0_w[SZ_LO+:2];
  assign dm0_w = ctl0_w[DST_LO+:2];
  assign sm0_w = ctl0_w[SRC_LO+:2];

  logic [31:0] ctl1_w;
  logic wr0_w;

  assign ctl1_w = ctrl_w[1];
  assign wr0_w = wr_go_w && (ch_w == 3'h0);

  reset_clear_a: assert property (
    disable iff (1'b0) $rose(rst_n_i) |-> (ctl0_w == CTRL_RST) && (ctl2_w == CTRL_RST))
    else $error("control not zero after reset");

  standby_hold_a: assert property (
    hold_w |=> $stable(ctl0_w) && $stable(src_w[0]) && $stable(dst_w[0]))
    else $error("state changed in standby");

  rsvd_zero_a: assert property (
    ctl0_w[31:24] == 8'h00 && ctl0_w[21:18] == 4'h0 && ctl2_w[31:24] == 8'h00)
    else $error("reserved control bits not zero");

  overrun_out_a: assert property (
    ##1 overrun_sel_o[0] == $past(ctl0_w[OVR_BIT]))
    else $error("overrun select does not follow control");

  end_level_a: assert property (
    !$past(hold_w) |-> xfer_end_out_o[0] == ($past(end_cycle_i[0]) ~^ $past(ctl0_w[TEP_BIT])))
    else $error("end output polarity wrong");

  dual_ack_a: assert property (
    !single_w[0] && !hold_w && (ctl0_w[ACS_BIT] ? wr_cycle_i[0] : rd_cycle_i[0])
    |=> xfer_ack_out_o[0] == $past(ctl0_w[ACP_BIT]))
    else $error("dual address ack missing");

  single_ack_a: assert property (
    single_w[0] && !hold_w && (rd_cycle_i[0] || wr_cycle_i[0])
    |=> xfer_ack_out_o[0] == $past(ctl0_w[ACP_BIT]))
    else $error("single address ack missing");

  ack_idle_a: assert property (
    !hold_w && !rd_cycle_i[0] && !wr_cycle_i[0]
    |=> xfer_ack_out_o[0] == !$past(ctl0_w[ACP_BIT]))
    else $error("ack idle level wrong");

  ext_only_a: assert property (
    ctl2_w[OVR_BIT] == 1'b0 && ctl2_w[TEP_BIT] == 1'b0 &&
    ctl2_w[ACS_BIT:ACP_BIT] == 2'b00)
    else $error("handshake bits set on internal channel");

  dst_inc_a: assert property (
    unit_done_i[0] && !hold_w && !to_dev_w[0] && !(wr_go_w && ch_w == 3'h0) &&
    dm0_w == DMC_INC && sz0_w == DMC_B16 |=> dst_w[0] == $past(dst_w[0]) + 32'h0000_0010)
    else $error("destination did not advance by 16");

  dst_dec_a: assert property (
    unit_done_i[0] && !hold_w && !to_dev_w[0] && !(wr_go_w && ch_w == 3'h0) &&
    dm0_w == DMC_DEC && sz0_w == DMC_LONG |=> dst_w[0] == $past(dst_w[0]) - 32'h0000_0004)
    else $error("destination did not step back by 4");

  src_word_a: assert property (
    unit_done_i[0] && !hold_w && !from_dev_w[0] && !(wr_go_w && ch_w == 3'h0) &&
    sm0_w == DMC_INC && sz0_w == DMC_WORD |=> src_w[0] == $past(src_w[0]) + 32'h0000_0002)
    else $error("source did not advance by 2");

  dst_ignore_a: assert property (
    to_dev_w[0] && !(wr_go_w && ch_w == 3'h0) |=> $stable(dst_w[0]))
    else $error("destination moved toward device");

  src_ignore_a: assert property (
    from_dev_w[0] && !(wr_go_w && ch_w == 3'h0) |=> $stable(src_w[0]))
    else $error("source moved from device");

  apb_answer_a: assert property (
    psel_i && penable_i && !pready_q |=> pready_q ##1 !pready_q)
    else $error("apb answer not one cycle");

  err_unmapped_a: assert property (
    psel_i && penable_i && !pready_q && !hit_w |=> pslverr_q && prdata_q == 32'h0000_0000)
    else $error("unmapped access not answered with error");

  rd_ctl_a: assert property (
    psel_i && penable_i && !pready_q && !pwrite_i && hit_w && sel_w == SEL_CTL &&
    ch_w == 3'h0 |=> prdata_q == $past(ctl0_w))
    else $error("control read data wrong");

  write_drop_a: assert property (
    done_w && pwrite_i && hold_w && sel_w == SEL_CTL && ch_w == 3'h2 |=> $stable(ctl2_w))
    else $error("control written in standby");

  // ----------------------------------------
  // assertions: channel 0 address steps
  // ----------------------------------------
  src_fixed_a: assert property (
    unit_done_i[0] && !wr0_w && sm0_w == DMC_FIXED |=> $stable(src_w[0]))
    else $error("fixed source moved");

  dst_fixed_a: assert property (
    unit_done_i[0] && !wr0_w && dm0_w == DMC_FIXED |=> $stable(dst_w[0]))
    else $error("fixed destination moved");

  src_dec_a: assert property (
    unit_done_i[0] && !hold_w && !from_dev_w[0] && !wr0_w && sm0_w == DMC_DEC &&
    sz0_w == DMC_BYTE |=> src_w[0] == $past(src_w[0]) - 32'h0000_0001)
    else $error("source did not step back by 1");

  dst_byte_a: assert property (
    unit_done_i[0] && !hold_w && !to_dev_w[0] && !wr0_w && dm0_w == DMC_INC &&
    sz0_w == DMC_BYTE |=> dst_w[0] == $past(dst_w[0]) + 32'h0000_0001)
    else $error("destination did not advance by 1");

  step_once_a: assert property (
    !unit_done_i[0] && !wr0_w |=> $stable(src_w[0]) && $stable(dst_w[0]))
    else $error("address moved without a unit");

  // ----------------------------------------
  // assertions: second external channel and internal channels 3 to 5
  // ----------------------------------------
  rsvd_zero1_a: assert property (
    ctl1_w[31:24] == 8'h00 && ctl1_w[21:18] == 4'h0)
    else $error("reserved control bits not zero on channel 1");

  int_chan_zero_a: assert property (
    ctrl_w[3][31:16] == 16'h0000 && ctrl_w[4][31:16] == 16'h0000 &&
    ctrl_w[5][31:16] == 16'h0000)
    else $error("upper control bits set on internal channel");

  overrun_out1_a: assert property (
    ##1 overrun_sel_o[1] == $past(ctl1_w[OVR_BIT]))
    else $error("overrun select does not follow control on channel 1");

  end_level1_a: assert property (
    !$past(hold_w) |-> xfer_end_out_o[1] == ($past(end_cycle_i[1]) ~^ $past(ctl1_w[TEP_BIT])))
    else $error("end output polarity wrong on channel 1");

  dual_ack1_a: assert property (
    !single_w[1] && !hold_w && (ctl1_w[ACS_BIT] ? wr_cycle_i[1] : rd_cycle_i[1])
    |=> xfer_ack_out_o[1] == $past(ctl1_w[ACP_BIT]))
    else $error("dual address ack missing on channel 1");

  single_ack1_a: assert property (
    single_w[1] && !hold_w && (rd_cycle_i[1] || wr_cycle_i[1])
    |=> xfer_ack_out_o[1] == $past(ctl1_w[ACP_BIT]))
    else $error("single address ack missing on channel 1");

  ack_idle1_a: assert property (
    !hold_w && !rd_cycle_i[1] && !wr_cycle_i[1]
    |=> xfer_ack_out_o[1] == !$past(ctl1_w[ACP_BIT]))
    else $error("ack idle level wrong on channel 1");

  cov_single_c: cover property (single_w[0] && rd_cycle_i[0] ##1 xfer_ack_out_o[0]);
  cov_ctl_write_c: cover property (wr_go_w && sel_w == SEL_CTL && ch_w == 3'h1);
  cov_b16_step_c: cover property (unit_done_i[0] && sz0_w == DMC_B16 && dm0_w == DMC_INC);
  cov_unmapped_c: cover property (pslverr_q);
  cov_dec_step_c: cover property (unit_done_i[0] && dm0_w == DMC_DEC && !to_dev_w[0]);
endmodule

/* pkg/dmc_pkg.sv */
package dmc_pkg;

  // ----------------------------------------
  // channel counts
  // ----------------------------------------
  localparam int unsigned NCH = 6;
  localparam int unsigned NEXT = 2;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int unsigned AW = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK_EXT = 32'h00c3_ffff;
  localparam logic [31:0] CTRL_MASK_INT = 32'h0000_ffff;
  localparam logic [1:0] SEL_SRC = 2'h0;
  localparam logic [1:0] SEL_DST = 2'h1;
  localparam logic [1:0] SEL_CTL = 2'h2;
  localparam logic [AW-1:0] CH_STRIDE = 8'h10;

  // ----------------------------------------
  // control field positions
  // ----------------------------------------
  localparam int unsigned OVR_BIT = 23;
  localparam int unsigned TEP_BIT = 22;
  localparam int unsigned ACS_BIT = 17;
  localparam int unsigned ACP_BIT = 16;
  localparam int unsigned DST_LO = 14;
  localparam int unsigned SRC_LO = 12;
  localparam int unsigned RS_LO = 8;
  localparam int unsigned SZ_LO = 3;
  localparam logic [3:0] RS_SGL_TO_DEV = 4'h2;
  localparam logic [3:0] RS_SGL_FROM_DEV = 4'h3;

  // ----------------------------------------
  // mode codes
  // ----------------------------------------
  typedef enum logic [1:0] {DMC_FIXED, DMC_INC, DMC_DEC, DMC_RSVD} dmc_step_t;
  typedef enum logic [1:0] {DMC_BYTE, DMC_WORD, DMC_LONG, DMC_B16} dmc_size_t;

endpackage

/* hdl/dmc_addr_step.sv */
`timescale 1ns/10ps
module dmc_addr_step (
  input wire logic [31:0] addr_i,
  input wire logic [1:0] mode_i,
  input wire logic [1:0] size_i,
  input wire logic ignore_i,
  output logic [31:0] next_o
);
  import dmc_pkg::*;

  logic [31:0] step_w;
  logic [31:0] inc_w;
  logic [31:0] dec_w;

  // step per unit: 1, 2, 4 or 16 bytes
  assign step_w = (size_i == DMC_BYTE) ? 32'h0000_0001 :
                  (size_i == DMC_WORD) ? 32'h0000_0002 :
                  (size_i == DMC_LONG) ? 32'h0000_0004 : 32'h0000_0010;
  assign inc_w = addr_i + step_w;
  assign dec_w = addr_i - step_w;

  always_comb begin
    next_o = addr_i;
    if (!ignore_i) begin
      case (dmc_step_t'(mode_i))
        DMC_INC: next_o = inc_w;
        // no decrement in 16-byte units
        DMC_DEC: next_o = (size_i == DMC_B16) ? addr_i : dec_w;
        default: next_o = addr_i;
      endcase
    end
  end
endmodule

/* hdl/dmc_hs_out.sv */
`timescale 1ns/10ps
module dmc_hs_out (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic hold_i,
  input wire logic single_i,
  input wire logic ack_on_write_i,
  input wire logic ack_high_i,
  input wire logic end_high_i,
  input wire logic rd_cycle_i,
  input wire logic wr_cycle_i,
  input wire logic end_cycle_i,
  output logic ack_o,
  output logic end_o
);
  logic ack_act_w;
  logic ack_q;
  logic end_q;

  // single address: ack on every read or write cycle; dual: read or write cycle only
  assign ack_act_w = single_i ? (rd_cycle_i | wr_cycle_i) :
                     (ack_on_write_i ? wr_cycle_i : rd_cycle_i);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'b1;
      end_q <= 1'b1;
    end else if (!hold_i) begin
      ack_q <= ack_act_w ~^ ack_high_i;
      end_q <= end_cycle_i ~^ end_high_i;
    end
  end

  assign ack_o = ack_q;
  assign end_o = end_q;
endmodule

/* verif/dmc_ext_dev.sv */
`timescale 1ns/10ps
module dmc_ext_dev (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic ack_high_i,
  input wire logic end_high_i,
  input wire logic ack_i,
  input wire logic end_i,
  output logic [7:0] ack_cnt_o,
  output logic [7:0] end_cnt_o
);
  // counts cycles at the active level inside a transfer window
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_cnt_o <= 8'h00;
      end_cnt_o <= 8'h00;
    end else if (en_i) begin
      ack_cnt_o <= ack_cnt_o + 8'(ack_i == ack_high_i);
      end_cnt_o <= end_cnt_o + 8'(end_i == end_high_i);
    end
  end
endmodule

/* verif/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import dmc_pkg::*;
  logic mclk_i, rst_n_i, psel, penable, pwrite, sby, mstop, pready, perr, err;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [NCH-1:0] udone;
  logic [NEXT-1:0] rdc, wrc, endc, ack, xfer_end_out, ovr, en, al, tl;
  logic [NCH*32-1:0] srco, dsto;
  logic [7:0] acnt [NEXT];
  logic [7:0] ecnt [NEXT];
  logic [31:0] ctl [NCH];
  logic [31:0] src [NCH];
  logic [31:0] dst [NCH];
  int n_fail, tests_run, c, sm, dm, sz, rs, act;
  int eack [NEXT];
  int eend [NEXT];
  integer seed = 32'h5f4c31c2;

  dmc_ctrl uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(perr), .standby_i(sby), .module_stop_i(mstop),
    .unit_done_i(udone), .rd_cycle_i(rdc), .wr_cycle_i(wrc), .end_cycle_i(endc),
    .xfer_ack_out_o(ack), .xfer_end_out_o(xfer_end_out), .overrun_sel_o(ovr),
    .src_addr_o(srco), .dst_addr_o(dsto));

  for (genvar g = 0; g < NEXT; g++) begin : g_dev
    dmc_ext_dev dev (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .en_i(en[g]), .ack_high_i(al[g]),
      .end_high_i(tl[g]), .ack_i(ack[g]), .end_i(xfer_end_out[g]), .ack_cnt_o(acnt[g]),
      .end_cnt_o(ecnt[g]));
  end

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("mismatches %0d of %0d checks", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input int a, input logic [31:0] d);
    int k;
    @(posedge mclk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= AW'(a);
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      stop_test();
    end
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input int ch, input int s, input logic [31:0] d);
    apb(1'b1, ch * 16 + s * 4, d);
    if (s == 0) src[ch] = d;
    else if (s == 1) dst[ch] = d;
    else ctl[ch] = d & (ch < NEXT ? CTRL_MASK_EXT : CTRL_MASK_INT);
  endtask

  task automatic rreg(input int ch, input int s);
    apb(1'b0, ch * 16 + s * 4, 32'h0);
    chk(rd, s == 0 ? src[ch] : s == 1 ? dst[ch] : ctl[ch]);
  endtask

  task automatic pulse(input int ch);
    @(posedge mclk_i);
    udone <= NCH'(1 << ch);
    @(posedge mclk_i);
    udone <= '0;
    @(posedge mclk_i);
  endtask

  function automatic logic [31:0] nxt(input logic [31:0] a, input int m, input int s, input bit ig);
    int st;
    st = (s == 3) ? 16 : (1 << s);
    if (ig || m == 0 || m == 3) return a;
    if (m == 1) return a + 32'(st);
    return (s == 3) ? a : a - 32'(st);
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst_n_i, psel, penable, pwrite, sby, mstop} = '0;
    {paddr, pwdata, udone, rdc, wrc, endc, en, al, tl} = '0;
    for (int i = 0; i < NCH; i++) begin
      {ctl[i], src[i], dst[i]} = '0;
    end
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < NCH * 3; i++) rreg(i / 3, i % 3);
    for (int i = 0; i < NCH; i++) begin
      wreg(i, 2, 32'hffffffff);
      rreg(i, 2);
      wreg(i, 2, $random(seed));
      rreg(i, 2);
    end
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, 8'h60, 32'h1);
    chk(32'(err), 32'h1);
    for (int i = 0; i < 48; i++) begin
      c = $unsigned($random(seed)) % NCH;
      sm = $unsigned($random(seed)) % 3;
      dm = $unsigned($random(seed)) % 3;
      sz = $unsigned($random(seed)) % 4;
      if (i < 2) begin
        c = 0;
        sm = 1;
        dm = 2;
        sz = 2 - i;
      end
      rs = (c < NEXT) ? (i % 3 == 0 ? 0 : 1 + i % 3) : 0;
      if (sz == 3) begin
        sm = 1;
        dm = 1;
      end
      wreg(c, 0, $random(seed));
      wreg(c, 1, $random(seed));
      wreg(c, 2, 32'((dm << 14) | (sm << 12) | (rs << 8) | (sz << 3)));
      pulse(c);
      src[c] = nxt(src[c], sm, sz, rs == 3);
      dst[c] = nxt(dst[c], dm, sz, rs == 2);
      chk(srco[c*32+:32], src[c]);
      chk(dsto[c*32+:32], dst[c]);
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk_i);
      sby <= (k == 0);
      mstop <= (k == 1);
      apb(1'b1, 8'h28, 32'h5555);
      pulse(2);
      rreg(2, 2);
      chk(srco[64+:32], src[2]);
      sby <= 1'b0;
      mstop <= 1'b0;
    end
    for (int i = 0; i < 32; i++) begin
      c = i % 2;
      rs = i[4] ? (i[1] ? 2 : 3) : 0;
      al[c] <= i[1];
      tl[c] <= i[2];
      v = 32'h0000_0000;
      v[23] = i[1] ^ i[2];
      v[22] = i[2];
      v[17] = i[3];
      v[16] = i[1];
      v[11:8] = 4'(rs);
      wreg(c, 2, v);
      for (int ph = 0; ph < 2; ph++) begin
        @(posedge mclk_i);
        rdc[c] <= (ph == 0);
        wrc[c] <= (ph == 1);
        endc[c] <= (ph == 1);
        @(posedge mclk_i);
        en[c] <= 1'b1;
        @(posedge mclk_i);
        act = (rs != 0) || (i[3] ? ph == 1 : ph == 0);
        chk(32'(ack[c]), 32'(al[c] ^ (act == 0)));
        chk(32'(xfer_end_out[c]), 32'(tl[c] ^ (ph == 0)));
        chk(32'(ovr[c]), 32'(i[1] ^ i[2]));
        eack[c] += act;
        eend[c] += ph;
        {en[c], rdc[c], wrc[c], endc[c]} <= 4'h0;
      end
    end
    repeat (2) @(posedge mclk_i);
    for (int i = 0; i < NEXT; i++) begin
      chk(32'(acnt[i]), 32'(eack[i]));
      chk(32'(ecnt[i]), 32'(eend[i]));
    end
    stop_test();
  end
endmodule
